/* File: io_port_params.svh */
// Purpose: offsets, field positions, reset values and timing counts of the io port
// Assumes: AXI4-Lite register slave, 32-bit words, byte addresses
// Notes: definitions only
`ifndef IO_PORT_PARAMS_SVH
`define IO_PORT_PARAMS_SVH

`define IOP_ADDR_W         6
`define IOP_OFF_DATA       6'h00
`define IOP_OFF_DIR        6'h04
`define IOP_OFF_PULLUP     6'h08
`define IOP_OFF_KEYPAD     6'h0C
`define IOP_OFF_ACHAN      6'h10
`define IOP_OFF_PINS       6'h14
`define IOP_DIR_RESET      8'h00
`define IOP_PULLUP_RESET   8'h00
`define IOP_KEYPAD_RESET   8'h00
`define IOP_ACHAN_RESET    5'h00
`define IOP_ACHAN_BASE     5'h08
`define IOP_ACHAN_W        5
`define IOP_SYNC_STAGES    2
`define IOP_RESP_OKAY      2'h0
`define IOP_RESP_DECERR    2'h3

`endif

/* File: io_port_pkg.sv */
// Purpose: types shared by the io port files
// Assumes: AXI4-Lite with 32-bit data
// Notes: carriers for the register bus channels
package io_port_pkg;

	typedef struct packed {
		logic [31:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [31:0] araddr;
		logic        arvalid;
		logic        rready;
	} axil_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} axil_rsp_s;

endpackage : io_port_pkg

/* File: io_pin_sync.sv */
// Purpose: two-stage synchroniser for the pin levels
// Assumes: single clock mclk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module io_pin_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : io_pin_sync
`default_nettype wire

/* File: io_port.sv */
// Purpose: 8-bit bidirectional io port shared with a keypad irq unit and a converter
// Assumes: 200 MHz mclk, synchronous active-low reset, AXI4-Lite register slave
// Notes: pin enables and pullups are registered, so they lag register writes by one cycle; pin_out follows the latch directly
// Operation
// - eight pins, each with a readable and writable data latch bit
// - reset leaves the data latch contents untouched
// - direction 1 drives the latch onto the pin; 0 makes it an input
// - reset clears all direction bits, every pin starts as input
// - output pins read back the stored latch value
// - input pins read back the present pin level
// - data writes with strobe bit 0 set update the latch, whatever the direction
// - per-pin pullup on inputs; output direction ignores the pullup setting
// - keypad enable bit passes its pin to the keypad irq unit
// - converter channel 8 to 15 forces pin 0 to 7 to analog input
// - pins not selected by the converter remain ordinary digital io
// - pullup drops one cycle after the pin turns output, returns one cycle after it is input again
//
// Design decision made here: register access over AXI4-Lite.
`include "io_port_params.svh"
`timescale 1ns/1ps
`default_nettype none
module io_port #(
	parameter int PINS = 8
) (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	// register bus
	input  wire io_port_pkg::axil_req_s s_axi_req,
	output var  io_port_pkg::axil_rsp_s s_axi_rsp,
	// pins
	input  wire logic [PINS-1:0]       pin_in,
	output var  logic [PINS-1:0]       pin_out,
	output var  logic [PINS-1:0]       pin_oe_n,
	output var  logic [PINS-1:0]       pin_pullup,
	// neighbouring units
	output var  logic [PINS-1:0]       keypad_inputs,
	output var  logic [PINS-1:0]       keypad_irq_enables,
	output var  logic [PINS-1:0]       analog_inputs_upper
);
	// registers
	logic [PINS-1:0]          port_data_latch;
	logic [PINS-1:0]          port_direction;
	logic [PINS-1:0]          port_pullup_enable;
	logic [`IOP_ACHAN_W-1:0]  analog_channel_select;
	logic [PINS-1:0]          pin_sync;
	logic [PINS-1:0]          analog_pins;
	logic [PINS-1:0]          next_read_port;
	logic                     latch_loaded;

	// bus state
	logic                     awready;
	logic                     wready;
	logic                     bvalid;
	logic [1:0]               bresp;
	logic                     arready;
	logic                     rvalid;
	logic [31:0]              rdata;
	logic [1:0]               rresp;
	logic [`IOP_ADDR_W-1:0]   wr_addr;
	logic [31:0]              wr_data;
	logic [3:0]               wr_strb;
	logic                     aw_held;
	logic                     w_held;
	logic                     wr_commit;
	logic                     wr_hit;
	logic                     aw_take;
	logic                     w_take;
	logic                     ar_take;
	logic [`IOP_ADDR_W-1:0]   ar_addr;

	// one-hot pin chosen by a converter channel, none outside 8..15
	function automatic logic [PINS-1:0] chan_to_pins(input logic [`IOP_ACHAN_W-1:0] ch);
		logic [`IOP_ACHAN_W-1:0] rel;
		chan_to_pins = '0;
		rel = ch - `IOP_ACHAN_BASE;
		if (ch >= `IOP_ACHAN_BASE && rel < `IOP_ACHAN_W'(PINS))
			chan_to_pins[rel[2:0]] = 1'b1;
	endfunction : chan_to_pins

	function automatic logic mapped(input logic [`IOP_ADDR_W-1:0] a);
		mapped = (a == `IOP_OFF_DATA) || (a == `IOP_OFF_DIR) || (a == `IOP_OFF_PULLUP)
			|| (a == `IOP_OFF_KEYPAD) || (a == `IOP_OFF_ACHAN) || (a == `IOP_OFF_PINS);
	endfunction : mapped

	io_pin_sync #(
		.WIDTH    (PINS)
	) u_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.async_in (pin_in),
		.sync_out (pin_sync)
	);

	assign analog_pins    = chan_to_pins(analog_channel_select);
	assign next_read_port = (port_direction & port_data_latch)
		| (~port_direction & pin_sync);

	assign aw_take   = s_axi_req.awvalid && awready;
	assign w_take    = s_axi_req.wvalid && wready;
	assign ar_take   = s_axi_req.arvalid && arready;
	assign wr_commit = aw_held && w_held && !bvalid;
	assign wr_hit    = wr_commit && wr_strb[0];
	assign ar_addr   = s_axi_req.araddr[`IOP_ADDR_W-1:0];

	// write address and data are caught in either order
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			awready <= 1'b1;
			aw_held <= 1'b0;
			wr_addr <= '0;
		end else if (aw_take) begin
			awready <= 1'b0;
			aw_held <= 1'b1;
			wr_addr <= s_axi_req.awaddr[`IOP_ADDR_W-1:0];
		end else if (bvalid && s_axi_req.bready) begin
			awready <= 1'b1;
		end else if (wr_commit) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wready  <= 1'b1;
			w_held  <= 1'b0;
			wr_data <= '0;
			wr_strb <= '0;
		end else if (w_take) begin
			wready  <= 1'b0;
			w_held  <= 1'b1;
			wr_data <= s_axi_req.wdata;
			wr_strb <= s_axi_req.wstrb;
		end else if (bvalid && s_axi_req.bready) begin
			wready  <= 1'b1;
		end else if (wr_commit) begin
			w_held  <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp  <= `IOP_RESP_OKAY;
		end else if (wr_commit) begin
			bvalid <= 1'b1;
			bresp  <= mapped(wr_addr) ? `IOP_RESP_OKAY : `IOP_RESP_DECERR;
		end else if (s_axi_req.bready) begin
			bvalid <= 1'b0;
		end
	end

	// no reset: latch keeps its contents across reset
	always_ff @(posedge mclk) begin
		if (wr_hit && wr_addr == `IOP_OFF_DATA)
			port_data_latch <= wr_data[PINS-1:0];
	end

	// power-up latch is unknown; checks on its contents wait for a first write
	always_ff @(posedge mclk) begin
		if (wr_hit && wr_addr == `IOP_OFF_DATA)
			latch_loaded <= 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			port_direction <= `IOP_DIR_RESET;
		else if (wr_hit && wr_addr == `IOP_OFF_DIR)
			port_direction <= wr_data[PINS-1:0];
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			port_pullup_enable <= `IOP_PULLUP_RESET;
		else if (wr_hit && wr_addr == `IOP_OFF_PULLUP)
			port_pullup_enable <= wr_data[PINS-1:0];
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			keypad_irq_enables <= `IOP_KEYPAD_RESET;
		else if (wr_hit && wr_addr == `IOP_OFF_KEYPAD)
			keypad_irq_enables <= wr_data[PINS-1:0];
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			analog_channel_select <= `IOP_ACHAN_RESET;
		else if (wr_hit && wr_addr == `IOP_OFF_ACHAN)
			analog_channel_select <= wr_data[`IOP_ACHAN_W-1:0];
	end

	// read channel, one access at a time
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= `IOP_RESP_OKAY;
		end else if (ar_take) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= mapped(ar_addr) ? `IOP_RESP_OKAY : `IOP_RESP_DECERR;
			unique case (ar_addr)
				`IOP_OFF_DATA:   rdata <= {24'h000000, next_read_port};
				`IOP_OFF_DIR:    rdata <= {24'h000000, port_direction};
				`IOP_OFF_PULLUP: rdata <= {24'h000000, port_pullup_enable};
				`IOP_OFF_KEYPAD: rdata <= {24'h000000, keypad_irq_enables};
				`IOP_OFF_ACHAN:  rdata <= {27'h0000000, analog_channel_select};
				`IOP_OFF_PINS:   rdata <= {24'h000000, pin_sync};
				default:         rdata <= 32'h00000000;
			endcase
		end else if (rvalid && s_axi_req.rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

	assign s_axi_rsp = '{awready: awready, wready: wready, bresp: bresp, bvalid: bvalid,
		arready: arready, rdata: rdata, rresp: rresp, rvalid: rvalid};

	// pin drive; latch goes out unchanged, only the enable gates it
	assign pin_out = port_data_latch;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pin_oe_n            <= '1;
			pin_pullup          <= '0;
			analog_inputs_upper <= '0;
		end else begin
			// converter claim beats direction and latch
			pin_oe_n            <= ~(port_direction & ~analog_pins);
			// pullup only on digital inputs
			pin_pullup          <= port_pullup_enable & ~port_direction
				& ~analog_pins;
			analog_inputs_upper <= analog_pins;
		end
	end

	// analog pins give the keypad unit nothing, avoiding false edges
	always_ff @(posedge mclk) begin
		if (!rst_n)
			keypad_inputs <= '0;
		else
			keypad_inputs <= pin_sync & keypad_irq_enables & ~analog_pins;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_dir_reset_clear: assert property (disable iff (1'b0)
		!rst_n |=> port_direction == 8'h00)
		else $error("direction not cleared by reset");

	a_latch_keeps_reset: assert property (disable iff (1'b0)
		(latch_loaded && !rst_n && !wr_hit)
		|=> port_data_latch == $past(port_data_latch))
		else $error("reset disturbed the data latch");

	a_latch_write_any: assert property (
		(wr_hit && wr_addr == `IOP_OFF_DATA) |=> port_data_latch == $past(wr_data[7:0]))
		else $error("data write did not reach the latch");

	a_read_mux_data: assert property (
		(ar_take && ar_addr == `IOP_OFF_DATA) |=> rvalid
		&& rdata[7:0] == (($past(port_direction) & $past(port_data_latch))
		| (~$past(port_direction) & $past(pin_sync))))
		else $error("data read mixes latch and pin wrongly");

	a_sync_two_stage: assert property (
		$past(rst_n, 2) |-> pin_sync == $past(pin_in, 2))
		else $error("pin level not delayed by two stages");

	a_drive_follows_dir: assert property (
		##1 pin_oe_n == ~($past(port_direction) & ~$past(analog_pins)))
		else $error("driver enable does not follow direction");

	a_analog_override: assert property (
		(analog_channel_select == 5'h08 && port_direction[0]) |=> pin_oe_n[0]
		&& !pin_pullup[0] && analog_inputs_upper[0])
		else $error("converter channel did not claim pin 0");

	a_pullup_off_output: assert property (
		##1 (pin_pullup & $past(port_direction)) == 8'h00)
		else $error("pullup active on an output pin");

	a_pullup_on_input: assert property (
		(port_pullup_enable[1] && !port_direction[1] && !analog_pins[1])
		|=> pin_pullup[1])
		else $error("enabled pullup missing on input pin");

	a_keypad_gate: assert property (
		##1 (keypad_inputs & ~$past(keypad_irq_enables)) == 8'h00)
		else $error("disabled pin reached keypad unit");

	a_write_answer: assert property (
		(aw_held && w_held && !bvalid) |=> bvalid [*1] ##0 !awready)
		else $error("write response missing");

	// bus handshake checks
	a_read_answer: assert property (
		ar_take |=> rvalid && !arready)
		else $error("read answer missing");

	a_write_release: assert property (
		(bvalid && s_axi_req.bready) |=> !bvalid && awready && wready)
		else $error("write channels not released after response");

	a_unmapped_read: assert property (
		(ar_take && !mapped(ar_addr))
		|=> rresp == `IOP_RESP_DECERR && rdata == 32'h00000000)
		else $error("unmapped read not refused");

	// pin path checks
	a_read_input_pin: assert property (
		(ar_take && ar_addr == `IOP_OFF_DATA)
		|=> ((rdata[7:0] ^ $past(pin_sync)) & ~$past(port_direction)) == 8'h00)
		else $error("input pin read does not show the pin level");

	a_latch_only_write: assert property (
		(latch_loaded && !(wr_hit && wr_addr == `IOP_OFF_DATA))
		|=> $stable(port_data_latch))
		else $error("data latch changed without a data write");

	a_keypad_follow: assert property (
		(keypad_irq_enables[7] && !analog_pins[7])
		|=> keypad_inputs[7] == $past(pin_sync[7]))
		else $error("enabled pin level not passed to keypad unit");

	a_analog_no_pull: assert property (
		##1 (pin_pullup & $past(analog_pins)) == 8'h00)
		else $error("pullup active on a converter pin");

	a_digital_keep: assert property (
		##1 ((~pin_oe_n ^ $past(port_direction)) & ~$past(analog_pins)) == 8'h00)
		else $error("unclaimed pin left direction control");

	c_write_data: cover property (wr_hit && wr_addr == `IOP_OFF_DATA);
	c_read_input: cover property (ar_take && ar_addr == `IOP_OFF_DATA && port_direction != 8'hFF);
	c_analog_claim: cover property (analog_pins != 8'h00 && port_direction != 8'h00);
	c_unmapped: cover property (bvalid && bresp == `IOP_RESP_DECERR);
	c_keypad_pass: cover property (keypad_inputs != 8'h00);

endmodule : io_port
`default_nettype wire

/* File: pin_model.sv */
// Purpose: external circuitry on the eight port pins
// Assumes: bench chooses which input pins it drives and to what level
// Notes: an undriven, unpulled pin toggles every cycle so a stale level never reads back
`timescale 1ns/1ps
`default_nettype none
module pin_model (
	// clock
	input  wire logic       mclk,
	// device side
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe_n,
	input  wire logic [7:0] pin_pullup,
	// bench side
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	// resolved levels
	output var  logic [7:0] pin_in
);
	logic [7:0] flt = 8'h55;

	always_ff @(posedge mclk) begin
		flt <= ~flt;
	end

	// device drive wins, then bench drive, then pullup, else floating
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_oe_n[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pin_pullup[i])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = flt[i];
		end
	end
endmodule : pin_model
`default_nettype wire

/* File: testbench.sv */
// Purpose: register-level tests of the io port
// Assumes: AXI4-Lite master tasks, pin model on the far side
// Notes: pin checks wait a few cycles for registered drivers and the synchroniser
`include "io_port_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
	logic                   mclk = 1'b0;
	logic                   rst_n = 1'b0;
	io_port_pkg::axil_req_s req;
	io_port_pkg::axil_rsp_s rsp;
	logic [7:0]             pin_in, pin_out, pin_oe_n, pin_pullup;
	logic [7:0]             kp_in, kp_en, an_up;
	logic [7:0]             ext_en = 8'h00;
	logic [7:0]             ext_val = 8'h00;
	logic [31:0]            rd;
	logic [1:0]             rs;
	int                     mismatches = 0;
	int                     total_checks = 0;

	initial begin
		forever #2.5 mclk = ~mclk;
	end

	io_port u_dut (.mclk(mclk), .rst_n(rst_n), .s_axi_req(req), .s_axi_rsp(rsp),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
		.keypad_inputs(kp_in), .keypad_irq_enables(kp_en), .analog_inputs_upper(an_up));

	pin_model u_pins (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

	task automatic wr(input logic [5:0] off, input logic [7:0] v, output logic [1:0] r);
		@(posedge mclk);
		req.awaddr <= {26'h0, off};
		req.awvalid <= 1'b1;
		req.wdata <= {24'h0, v};
		req.wstrb <= 4'hF;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		// each channel is released at its own handshake edge
		fork
			begin
				do @(negedge mclk); while (rsp.awready !== 1'b1);
				@(posedge mclk);
				req.awvalid <= 1'b0;
			end
			begin
				do @(negedge mclk); while (rsp.wready !== 1'b1);
				@(posedge mclk);
				req.wvalid <= 1'b0;
			end
		join
		while (rsp.bvalid !== 1'b1) @(negedge mclk);
		r = rsp.bresp;
		@(posedge mclk);
		req.bready <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [5:0] off, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		req.araddr <= {26'h0, off};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do @(negedge mclk); while (rsp.arready !== 1'b1);
		@(posedge mclk);
		req.arvalid <= 1'b0;
		while (rsp.rvalid !== 1'b1) @(negedge mclk);
		d = rsp.rdata;
		r = rsp.rresp;
		@(posedge mclk);
		req.rready <= 1'b0;
	endtask : rdr

	task automatic settle();
		repeat (4) @(posedge mclk);
		@(negedge mclk);
	endtask : settle

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		wrap_up();
	end

	initial begin
		req <= '0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		settle();
		`CHK(pin_oe_n, 8'hFF)
		rdr(`IOP_OFF_DIR, rd, rs);
		`CHK(rd, 32'h0000_0000)
		$display("test reset_values done");

		// latch loaded before the direction change, then survives a reset
		wr(`IOP_OFF_DATA, 8'h5A, rs);
		`CHK(rs, `IOP_RESP_OKAY)
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		wr(`IOP_OFF_DIR, 8'hFF, rs);
		settle();
		rdr(`IOP_OFF_DATA, rd, rs);
		`CHK(rd, 32'h0000_005A)
		`CHK(pin_out, 8'h5A)
		`CHK(pin_oe_n, 8'h00)
		$display("test latch_keep done");

		wr(`IOP_OFF_DIR, 8'h0F, rs);
		ext_en <= 8'hF0;
		ext_val <= 8'hA0;
		wr(`IOP_OFF_DATA, 8'h3C, rs);
		settle();
		rdr(`IOP_OFF_DATA, rd, rs);
		`CHK(rd, 32'h0000_00AC)
		`CHK(pin_out, 8'h3C)
		`CHK(pin_oe_n, 8'hF0)
		$display("test mixed_dir done");

		ext_en <= 8'h00;
		wr(`IOP_OFF_PULLUP, 8'hFF, rs);
		settle();
		`CHK(pin_pullup, 8'hF0)
		rdr(`IOP_OFF_DATA, rd, rs);
		`CHK(rd, 32'h0000_00FC)
		wr(`IOP_OFF_DIR, 8'h00, rs);
		settle();
		`CHK(pin_pullup, 8'hFF)
		rdr(`IOP_OFF_PINS, rd, rs);
		`CHK(rd, 32'h0000_00FF)
		rdr(`IOP_OFF_PULLUP, rd, rs);
		`CHK(rd, 32'h0000_00FF)
		$display("test pullup done");

		wr(`IOP_OFF_KEYPAD, 8'h81, rs);
		settle();
		`CHK(kp_en, 8'h81)
		`CHK(kp_in, 8'h81)
		rdr(`IOP_OFF_KEYPAD, rd, rs);
		`CHK(rd, 32'h0000_0081)
		$display("test keypad done");

		wr(`IOP_OFF_DIR, 8'hFF, rs);
		for (int ch = 8; ch < 16; ch++) begin
			wr(`IOP_OFF_ACHAN, 8'(ch), rs);
			settle();
			`CHK(an_up, 8'(1 << (ch - 8)))
			`CHK(pin_oe_n, 8'(1 << (ch - 8)))
		end
		rdr(`IOP_OFF_ACHAN, rd, rs);
		`CHK(rd, 32'h0000_000F)
		wr(`IOP_OFF_ACHAN, 8'h00, rs);
		settle();
		`CHK(an_up, 8'h00)
		`CHK(pin_oe_n, 8'h00)
		$display("test analog done");

		wr(6'h3C, 8'hFF, rs);
		`CHK(rs, `IOP_RESP_DECERR)
		rdr(6'h3C, rd, rs);
		`CHK(rs, `IOP_RESP_DECERR)
		`CHK(rd, 32'h0000_0000)
		rdr(`IOP_OFF_DATA, rd, rs);
		`CHK(rs, `IOP_RESP_OKAY)
		`CHK(rd, 32'h0000_003C)
		$display("test unmapped done");
		wrap_up();
	end
endmodule : testbench
`undef CHK
`default_nettype wire
